// *** hdl/slnp_pkg.sv ***
// Constants shared by the ladder node protocol block.
// Assumes a 100 MHz system clock; link events arrive as byte-level codes.
package slnp_pkg;
	// Link event kinds
	localparam logic [1:0] SLNP_K_BYTE  = 2'h0;
	localparam logic [1:0] SLNP_K_START = 2'h1;
	localparam logic [1:0] SLNP_K_STOP  = 2'h2;
	localparam logic [1:0] SLNP_K_ACK   = 2'h3;
	// Frame codes
	localparam logic [7:0] SLNP_BCAST_WR   = 8'h40;
	localparam logic [7:0] SLNP_BCAST_RD   = 8'h41;
	localparam logic [1:0] SLNP_WR_PREFIX  = 2'h2;
	localparam logic [7:0] SLNP_ASSIGN_CMD = 8'hA5;
	localparam logic [7:0] SLNP_CRC_POLY   = 8'h07;
	localparam logic [7:0] SLNP_CRC_INIT   = 8'h00;
	// Check byte fields
	localparam int SLNP_CHK_ALARM_BIT = 7;
	localparam int SLNP_CHK_ERR_BIT   = 0;
	// Timing
	localparam int SLNP_CLK_PERIOD_NS  = 10;
	localparam int SLNP_FWD_DELAY_NS   = 1000;
	localparam int SLNP_FWD_CYCLES     = SLNP_FWD_DELAY_NS / SLNP_CLK_PERIOD_NS;
	localparam int SLNP_TIMEOUT_MS     = 28;
	localparam int SLNP_TIMEOUT_CYCLES = (SLNP_TIMEOUT_MS * 1000000 + SLNP_CLK_PERIOD_NS - 1) / SLNP_CLK_PERIOD_NS;
endpackage

// *** hdl/slnp_node.sv ***
// Command handling for one node of a daisy-chained battery monitor ladder.
// Assumes outside link logic turns the pins into byte events and sends bytes;
// events on one port are spaced far more than a few system clocks apart.
`timescale 1ns/1ps
`default_nettype none

module slnp_node #(
	parameter int TIMEOUT_CYCLES = slnp_pkg::SLNP_TIMEOUT_CYCLES,
	parameter int FWD_CYCLES     = slnp_pkg::SLNP_FWD_CYCLES,
	parameter int BUF_DEPTH      = 4
) (
	input  wire logic        clk_sys_in,
	input  wire logic        reset_n_in,
	input  wire logic        clk_link_in,
	input  wire logic        lo_rx_valid_in,
	input  wire logic [1:0]  lo_rx_kind_in,
	input  wire logic [7:0]  lo_rx_byte_in,
	input  wire logic        up_rx_valid_in,
	input  wire logic [1:0]  up_rx_kind_in,
	input  wire logic [7:0]  up_rx_byte_in,
	input  wire logic        upper_port_clock_in,
	input  wire logic        lower_alarm_line_in,
	input  wire logic [4:0]  last_addr_in,
	input  wire logic        crc_alarm_enable_in,
	input  wire logic        crc_alert_clear_in,
	input  wire logic [15:0] reg_rd_data_in,
	output logic [7:0]       lo_tx_byte_out,
	output logic             lo_tx_tgl_out,
	output logic [1:0]       up_tx_kind_out,
	output logic [7:0]       up_tx_byte_out,
	output logic             up_tx_tgl_out,
	output logic [7:0]       reg_addr_out,
	output logic             wr_stb_out,
	output logic [15:0]      wr_data_out,
	output logic [4:0]       own_addr_out,
	output logic             crc_alert_status_out,
	output logic             alarm_out
);
	localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

	initial
	begin
		if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0)
			$error("BUF_DEPTH must be a power of two of at least 2");
		if (FWD_CYCLES < 2 || FWD_CYCLES > 255 || TIMEOUT_CYCLES < 4)
			$error("Cycle counts out of range");
	end

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_WR, ST_BCMD, ST_BDATA, ST_RS, ST_RADDR, ST_RD, ST_DONE
	} slnp_state_type;

	typedef struct packed {
		logic       lo_tgl;
		logic [1:0] lo_kind;
		logic [7:0] lo_byte;
		logic       up_tgl;
		logic [1:0] up_kind;
		logic [7:0] up_byte;
	} slnp_link_type;

	typedef struct packed {
		logic                      ucl_m, ucl_s, ucl_p;
		logic                      alm_m, alm_s;
		logic                      lo_m, lo_s, lo_p;
		logic                      up_m, up_s, up_p;
		logic [31:0]               to_cnt;
		slnp_state_type            st;
		logic                      fwd_on;
		logic                      fw_pend, fw_sta;
		logic [7:0]                fw_cnt;
		logic [1:0]                fw_kind;
		logic [7:0]                fw_byte;
		logic [1:0]                up_kind;
		logic [7:0]                up_byte;
		logic                      up_tgl;
		logic [7:0]                lo_byte;
		logic                      lo_tgl;
		logic                      lo_busy;
		logic [4:0]                own;
		logic [4:0]                tgt;
		logic [1:0]                idx;
		logic [7:0]                cmd, dlo, dhi;
		logic [7:0]                crc_lo, crc_up;
		logic                      wr_stb;
		logic                      alert;
		logic                      alarm;
		logic [6:0]                tx_i, up_i;
		logic [7:0]                up_chk;
		logic                      up_done, up_bad;
		logic [BUF_DEPTH-1:0][7:0] buf_mem;
		logic [PW-1:0]             wp, rp;
		logic [PW:0]               cnt;
	} slnp_sys_type;

	// CRC-8, one byte, MSB first
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] r;
		r = c ^ b;
		for (int i = 0; i < 8; i++)
			r = r[7] ? ({r[6:0], 1'b0} ^ slnp_pkg::SLNP_CRC_POLY) : {r[6:0], 1'b0};
		return r;
	endfunction

	// Node address travels LSB first in the address byte
	function automatic logic [4:0] addr_of(input logic [7:0] b);
		return {b[1], b[2], b[3], b[4], b[5]};
	endfunction

	// Reset release, one copy per domain
	logic [1:0] rs_sys_q;
	logic [1:0] rs_lnk_q;
	logic       rst_sys_n;
	logic       rst_lnk_n;
	assign rst_sys_n = rs_sys_q[1];
	assign rst_lnk_n = rs_lnk_q[1];

	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			rs_sys_q <= 2'h0;
		else
			rs_sys_q <= {rs_sys_q[0], 1'b1};
	end

	always_ff @(posedge clk_link_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			rs_lnk_q <= 2'h0;
		else
			rs_lnk_q <= {rs_lnk_q[0], 1'b1};
	end

	// Link side: each event is held and announced by a toggle
	slnp_link_type l_q;
	slnp_link_type l_d;

	always_comb
	begin
		l_d = l_q;
		if (lo_rx_valid_in)
		begin
			l_d.lo_tgl  = ~l_q.lo_tgl;
			l_d.lo_kind = lo_rx_kind_in;
			l_d.lo_byte = lo_rx_byte_in;
		end
		if (up_rx_valid_in)
		begin
			l_d.up_tgl  = ~l_q.up_tgl;
			l_d.up_kind = up_rx_kind_in;
			l_d.up_byte = up_rx_byte_in;
		end
	end

	always_ff @(posedge clk_link_in or negedge rst_lnk_n)
	begin
		if (!rst_lnk_n)
			l_q <= '0;
		else
			l_q <= l_d;
	end

	// System side
	slnp_sys_type s_q;
	slnp_sys_type s_d;

	logic       lo_ev, up_ev, timeout, is_last;
	logic       q_fwd, q_sta, push, pop;
	logic [1:0] q_kind;
	logic [7:0] q_byte, b, chk, tx_b;
	logic [6:0] n_up, n_data;

	always_comb
	begin
		s_d = s_q;
		q_fwd = 1'b0;
		q_sta = 1'b0;
		q_kind = slnp_pkg::SLNP_K_BYTE;
		q_byte = 8'h00;
		push = 1'b0;
		pop = 1'b0;
		tx_b = 8'h00;
		// Toggle data is stable long before the synchronised toggle moves
		b = l_q.lo_byte;
		s_d.ucl_m = upper_port_clock_in;
		s_d.ucl_s = s_q.ucl_m;
		s_d.ucl_p = s_q.ucl_s;
		s_d.alm_m = lower_alarm_line_in;
		s_d.alm_s = s_q.alm_m;
		s_d.lo_m = l_q.lo_tgl;
		s_d.lo_s = s_q.lo_m;
		s_d.lo_p = s_q.lo_s;
		s_d.up_m = l_q.up_tgl;
		s_d.up_s = s_q.up_m;
		s_d.up_p = s_q.up_s;
		lo_ev = s_q.lo_s ^ s_q.lo_p;
		up_ev = s_q.up_s ^ s_q.up_p;
		s_d.wr_stb = 1'b0;
		// Clear first so that a new alert in the same cycle wins over it
		if (crc_alert_clear_in)
			s_d.alert = 1'b0;
		is_last = (s_q.own == last_addr_in);
		n_up = {1'b0, 5'(last_addr_in - s_q.own), 1'b0};
		n_data = 7'(n_up + 7'h02);
		chk = 8'h00;
		chk[slnp_pkg::SLNP_CHK_ALARM_BIT] = s_q.alm_s | (!is_last & s_q.up_chk[7]);
		chk[slnp_pkg::SLNP_CHK_ERR_BIT] = !is_last & (s_q.up_bad | s_q.up_chk[0]);

		// Stuck upper clock; fires once as the limit is reached
		if (s_q.ucl_s != s_q.ucl_p)
			s_d.to_cnt = 32'h0;
		else if (s_q.to_cnt != 32'(TIMEOUT_CYCLES))
			s_d.to_cnt = s_q.to_cnt + 32'h1;
		timeout = (s_q.ucl_s == s_q.ucl_p) && (s_q.to_cnt == 32'(TIMEOUT_CYCLES - 1));

		// Delayed re-drive upward, one event in flight
		if (s_q.fw_pend)
		begin
			if (s_q.fw_cnt != 8'h00)
				s_d.fw_cnt = s_q.fw_cnt - 8'h01;
			else if (s_q.fw_sta)
			begin
				s_d.up_kind = slnp_pkg::SLNP_K_START;
				s_d.up_tgl = ~s_q.up_tgl;
				s_d.fw_sta = 1'b0;
				s_d.fw_cnt = 8'h01;
			end
			else
			begin
				s_d.up_kind = s_q.fw_kind;
				s_d.up_byte = s_q.fw_byte;
				s_d.up_tgl = ~s_q.up_tgl;
				s_d.fw_pend = 1'b0;
			end
		end

		if (lo_ev)
		begin
			unique case (l_q.lo_kind)
				slnp_pkg::SLNP_K_ACK:
					s_d.lo_busy = 1'b0;
				slnp_pkg::SLNP_K_START:
					if (s_q.st == ST_RS)
					begin
						s_d.st = ST_RADDR;
						q_fwd = 1'b1;
						q_kind = slnp_pkg::SLNP_K_START;
					end
					else
					begin
						s_d.st = ST_ADDR;
						s_d.fwd_on = 1'b0;
					end
				slnp_pkg::SLNP_K_STOP:
				begin
					s_d.st = ST_IDLE;
					s_d.fwd_on = 1'b0;
					q_fwd = s_q.fwd_on;
					q_kind = slnp_pkg::SLNP_K_STOP;
				end
				slnp_pkg::SLNP_K_BYTE:
				begin
					q_byte = b;
					unique case (s_q.st)
						ST_ADDR:
						begin
							s_d.crc_lo = crc8(slnp_pkg::SLNP_CRC_INIT, b);
							if (b[7:6] == slnp_pkg::SLNP_WR_PREFIX && !b[0])
							begin
								s_d.tgt = addr_of(b);
								s_d.fwd_on = addr_of(b) > s_q.own;
								q_fwd = addr_of(b) > s_q.own;
								q_sta = 1'b1;
								s_d.idx = 2'h0;
								s_d.st = ST_WR;
							end
							else if (b == slnp_pkg::SLNP_BCAST_WR)
							begin
								s_d.fwd_on = 1'b1;
								q_fwd = 1'b1;
								q_sta = 1'b1;
								s_d.st = ST_BCMD;
							end
							else
								s_d.st = ST_DONE;
						end
						ST_WR:
						begin
							q_fwd = s_q.fwd_on;
							s_d.idx = s_q.idx + 2'h1;
							if (s_q.idx != 2'h3)
								s_d.crc_lo = crc8(s_q.crc_lo, b);
							unique case (s_q.idx)
								2'h0: s_d.cmd = b;
								2'h1: s_d.dlo = b;
								2'h2: s_d.dhi = b;
								2'h3:
								begin
									s_d.st = ST_DONE;
									if (s_q.tgt == s_q.own)
									begin
										if (b == s_q.crc_lo)
											s_d.wr_stb = 1'b1;
										else
											s_d.alert = 1'b1;
									end
								end
							endcase
						end
						ST_BCMD:
						begin
							q_fwd = 1'b1;
							s_d.cmd = b;
							s_d.crc_lo = crc8(s_q.crc_lo, b);
							s_d.st = (b == slnp_pkg::SLNP_ASSIGN_CMD) ? ST_BDATA : ST_RS;
						end
						ST_BDATA:
						begin
							s_d.own = b[4:0];
							q_fwd = 1'b1;
							q_byte = {3'h0, 5'(b[4:0] + 5'h01)};
							s_d.st = ST_DONE;
						end
						ST_RADDR:
						begin
							q_fwd = 1'b1;
							if (b == slnp_pkg::SLNP_BCAST_RD)
							begin
								s_d.crc_lo = crc8(s_q.crc_lo, b);
								s_d.crc_up = crc8(s_q.crc_lo, b);
								s_d.st = ST_RD;
								s_d.tx_i = 7'h0;
								s_d.up_i = 7'h0;
								s_d.up_chk = 8'h00;
								s_d.up_done = 1'b0;
								s_d.up_bad = 1'b0;
								s_d.lo_busy = 1'b0;
								s_d.wp = '0;
								s_d.rp = '0;
								s_d.cnt = '0;
							end
							else
								s_d.st = ST_DONE;
						end
						ST_RS, ST_RD:
							q_fwd = s_q.fwd_on;
						ST_IDLE, ST_DONE:
							q_fwd = 1'b0;
					endcase
				end
			endcase
		end

		// Bytes arriving at the upper port during a stack read
		if (up_ev && s_q.st == ST_RD && l_q.up_kind == slnp_pkg::SLNP_K_BYTE && !s_q.up_done)
		begin
			s_d.up_i = s_q.up_i + 7'h1;
			if (s_q.up_i < n_up)
			begin
				push = s_q.cnt != (PW + 1)'(BUF_DEPTH);
				s_d.crc_up = crc8(s_q.crc_up, l_q.up_byte);
			end
			else if (s_q.up_i == n_up)
			begin
				s_d.up_chk = l_q.up_byte;
				s_d.crc_up = crc8(s_q.crc_up, l_q.up_byte);
			end
			else
			begin
				s_d.up_done = 1'b1;
				// Flag only; the stream carries on
				if (l_q.up_byte != s_q.crc_up)
				begin
					s_d.up_bad = 1'b1;
					s_d.alert = 1'b1;
				end
			end
		end

		// Sending toward the host, one byte per acknowledge
		if (s_q.st == ST_RD && !s_q.lo_busy && s_q.tx_i <= n_data + 7'h1)
		begin
			if (s_q.tx_i == 7'h0)
			begin
				tx_b = reg_rd_data_in[7:0];
				s_d.lo_busy = 1'b1;
			end
			else if (s_q.tx_i == 7'h1)
			begin
				tx_b = reg_rd_data_in[15:8];
				s_d.lo_busy = 1'b1;
			end
			else if (s_q.tx_i < n_data)
			begin
				if (s_q.cnt != '0)
				begin
					tx_b = s_q.buf_mem[s_q.rp];
					pop = 1'b1;
					s_d.lo_busy = 1'b1;
				end
			end
			else if (s_q.tx_i == n_data)
			begin
				if (is_last || s_q.up_done)
				begin
					tx_b = chk;
					s_d.lo_busy = 1'b1;
				end
			end
			else
			begin
				tx_b = s_q.crc_lo;
				s_d.lo_busy = 1'b1;
			end
			if (s_d.lo_busy)
			begin
				s_d.lo_byte = tx_b;
				s_d.lo_tgl = ~s_q.lo_tgl;
				s_d.tx_i = s_q.tx_i + 7'h1;
				if (s_q.tx_i != n_data + 7'h1)
					s_d.crc_lo = crc8(s_q.crc_lo, tx_b);
			end
		end

		if (push)
		begin
			s_d.buf_mem[s_q.wp] = l_q.up_byte;
			s_d.wp = s_q.wp + PW'(1);
		end
		if (pop)
			s_d.rp = s_q.rp + PW'(1);
		s_d.cnt = s_q.cnt + (PW + 1)'(push) - (PW + 1)'(pop);

		if (q_fwd)
		begin
			s_d.fw_pend = 1'b1;
			s_d.fw_sta = q_sta;
			s_d.fw_cnt = 8'(FWD_CYCLES - 2);
			s_d.fw_kind = q_kind;
			s_d.fw_byte = q_byte;
		end

		// Abort behaves as a stop without passing one on
		if (timeout)
		begin
			s_d.st = ST_IDLE;
			s_d.fwd_on = 1'b0;
			s_d.fw_pend = 1'b0;
			s_d.lo_busy = 1'b0;
		end

		s_d.alarm = s_d.alert & crc_alarm_enable_in;
	end

	always_ff @(posedge clk_sys_in or negedge rst_sys_n)
	begin
		if (!rst_sys_n)
		begin
			s_q <= '0;
			s_q.st <= ST_IDLE;
		end
		else
			s_q <= s_d;
	end

	assign lo_tx_byte_out       = s_q.lo_byte;
	assign lo_tx_tgl_out        = s_q.lo_tgl;
	assign up_tx_kind_out       = s_q.up_kind;
	assign up_tx_byte_out       = s_q.up_byte;
	assign up_tx_tgl_out        = s_q.up_tgl;
	assign reg_addr_out         = s_q.cmd;
	assign wr_stb_out           = s_q.wr_stb;
	assign wr_data_out          = {s_q.dhi, s_q.dlo};
	assign own_addr_out         = s_q.own;
	assign crc_alert_status_out = s_q.alert;
	assign alarm_out            = s_q.alarm;
endmodule
`default_nettype wire

// *** sim/slnp_node_properties.sv ***
// Port checker for the ladder node, system clock domain only.
// Assumes it is bound to slnp_node and sees nothing but its ports.
`timescale 1ns/1ps
`default_nettype none
module slnp_node_chk (
	input wire logic       clk_sys_in,
	input wire logic       reset_n_in,
	input wire logic       crc_alarm_enable_in,
	input wire logic       crc_alert_clear_in,
	input wire logic [7:0] lo_tx_byte_out,
	input wire logic       lo_tx_tgl_out,
	input wire logic [1:0] up_tx_kind_out,
	input wire logic [7:0] up_tx_byte_out,
	input wire logic       up_tx_tgl_out,
	input wire logic       wr_stb_out,
	input wire logic       crc_alert_status_out,
	input wire logic       alarm_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);
	chk_alarm_stays_off: assert property ((!crc_alarm_enable_in) [*2] |-> !alarm_out)
		else $error("alarm raised while disabled");
	chk_alarm_follows_alert: assert property ((crc_alert_status_out && crc_alarm_enable_in) [*2] |-> alarm_out)
		else $error("enabled alert gave no alarm");
	chk_alert_is_sticky: assert property (crc_alert_status_out && !crc_alert_clear_in |=> crc_alert_status_out)
		else $error("alert dropped without clear");
	chk_strobe_one_cycle: assert property (wr_stb_out |=> !wr_stb_out)
		else $error("write strobe longer than one cycle");
	chk_strobe_no_relay: assert property (wr_stb_out |-> $stable(up_tx_tgl_out))
		else $error("own write relayed upward");
	chk_up_toggle_gap: assert property ($changed(up_tx_tgl_out) |=> $stable(up_tx_tgl_out))
		else $error("upward events back to back");
	chk_up_event_hold: assert property ($changed(up_tx_byte_out) || $changed(up_tx_kind_out)
		|-> $changed(up_tx_tgl_out))
		else $error("upward event changed without toggle");
	chk_lo_byte_hold: assert property ($changed(lo_tx_byte_out) |-> $changed(lo_tx_tgl_out))
		else $error("lower byte changed without toggle");
endmodule
bind slnp_node slnp_node_chk u_chk (.clk_sys_in, .reset_n_in, .crc_alarm_enable_in, .crc_alert_clear_in,
	.lo_tx_byte_out, .lo_tx_tgl_out, .up_tx_kind_out, .up_tx_byte_out, .up_tx_tgl_out, .wr_stb_out,
	.crc_alert_status_out, .alarm_out);
`default_nettype wire

// *** sim/slnp_link_model.sv ***
// Event source standing in for the host or the neighbour node on one port.
// Assumes a free-running link clock; events spaced wider than the forward slot.
`timescale 1ns/1ps
`default_nettype none
module slnp_link_model (
	input  wire logic  clk_link_in,
	output logic       valid_out,
	output logic [1:0] kind_out,
	output logic [7:0] byte_out
);
	initial
	begin
		valid_out = 1'b0;
		kind_out = 2'h0;
		byte_out = 8'h00;
	end
	// Released lines show the inverse so a stale value is never trusted
	task send(input logic [1:0] k, input logic [7:0] b);
		@(negedge clk_link_in);
		valid_out = 1'b1;
		kind_out = k;
		byte_out = b;
		@(negedge clk_link_in);
		valid_out = 1'b0;
		kind_out = ~k;
		byte_out = ~b;
		repeat (30) @(negedge clk_link_in);
	endtask
endmodule
`default_nettype wire

// *** sim/tb_stack_ladder_node_protocol.sv ***
// Self-checking bench for one ladder node: assign, writes, timeout, stack reads.
// Assumes slnp_node, the checker and two link models; short timeout and forward counts.
`timescale 1ns/1ps
`default_nettype none
module tb_stack_ladder_node_protocol;
	logic        clk_sys_in = 0, clk_link_in = 0, reset_n_in = 0, uclk_run = 1, lo_p = 0, up_p = 0;
	logic        lo_v, up_v, lo_tx_tgl_out, up_tx_tgl_out, wr_stb_out, crc_alert_status_out, alarm_out;
	logic        upper_port_clock_in = 0, lower_alarm_line_in = 0, crc_alarm_enable_in = 0, crc_alert_clear_in = 0;
	logic [1:0]  lo_k, up_k, up_tx_kind_out;
	logic [7:0]  lo_b, up_b, lo_tx_byte_out, up_tx_byte_out, reg_addr_out;
	logic [4:0]  last_addr_in = 0, own_addr_out;
	logic [15:0] reg_rd_data_in = 0, wr_data_out;
	logic [23:0] stb_v;
	logic [7:0]  q[$];
	int          num_errors = 0, checks_done = 0, n_stb = 0, n_up = 0, seed = 75;
	slnp_node #(.TIMEOUT_CYCLES(200), .FWD_CYCLES(20)) DUT (.clk_sys_in, .reset_n_in, .clk_link_in,
		.lo_rx_valid_in(lo_v), .lo_rx_kind_in(lo_k), .lo_rx_byte_in(lo_b), .up_rx_valid_in(up_v),
		.up_rx_kind_in(up_k), .up_rx_byte_in(up_b), .upper_port_clock_in, .lower_alarm_line_in, .last_addr_in,
		.crc_alarm_enable_in, .crc_alert_clear_in, .reg_rd_data_in, .lo_tx_byte_out, .lo_tx_tgl_out,
		.up_tx_kind_out, .up_tx_byte_out, .up_tx_tgl_out, .reg_addr_out, .wr_stb_out, .wr_data_out,
		.own_addr_out, .crc_alert_status_out, .alarm_out);
	slnp_link_model LO (.clk_link_in, .valid_out(lo_v), .kind_out(lo_k), .byte_out(lo_b));
	slnp_link_model UP (.clk_link_in, .valid_out(up_v), .kind_out(up_k), .byte_out(up_b));
	always #5 clk_sys_in = ~clk_sys_in;
	always #24 clk_link_in = ~clk_link_in;
	// Upper clock keeps moving so only the deliberate stall can time out
	always
	begin
		repeat (50) @(negedge clk_sys_in);
		if (uclk_run) upper_port_clock_in <= ~upper_port_clock_in;
	end
	always @(posedge clk_sys_in)
	begin
		if (wr_stb_out === 1'b1) n_stb++;
		if (wr_stb_out === 1'b1) stb_v = {reg_addr_out, wr_data_out};
		if (lo_tx_tgl_out !== lo_p) q.push_back(lo_tx_byte_out);
		if (up_tx_tgl_out !== up_p) n_up++;
		lo_p = lo_tx_tgl_out;
		up_p = up_tx_tgl_out;
	end
	function automatic logic [7:0] crcq(input logic [7:0] s[$]);
		logic [7:0] c;
		c = 8'h00;
		foreach (s[i])
		begin
			c = c ^ s[i];
			repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
		end
		return c;
	endfunction
	function automatic logic [7:0] wb(input logic [4:0] a);
		return {slnp_pkg::SLNP_WR_PREFIX, a[0], a[1], a[2], a[3], a[4], 1'b0};
	endfunction
	task give_verdict;
		if (num_errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e)
		begin
			$display("mismatch %s expected %h seen %h", nm, e, s);
			num_errors++;
		end
	endtask
	task frame(input logic [7:0] b[$]);
		LO.send(slnp_pkg::SLNP_K_START, 8'h00);
		foreach (b[i]) LO.send(slnp_pkg::SLNP_K_BYTE, b[i]);
	endtask
	task wq(input int n);
		for (int i = 0; i < 6000; i++)
		begin
			if (q.size() >= n) return;
			@(negedge clk_sys_in);
		end
		num_errors++;
		give_verdict();
	endtask
	initial
	begin
		logic [4:0] own, tgt;
		logic [7:0] r, l8, h8, ub[$], ex[$];
		int n0, s0;
		repeat (20) @(negedge clk_sys_in);
		reset_n_in = 1;
		repeat (5) @(negedge clk_sys_in);
		for (int j = 0; j < 2; j++)
		begin
			own = j ? 5'h01 + 5'({$random(seed)} % 29) : 5'h1F;
			frame('{slnp_pkg::SLNP_BCAST_WR, slnp_pkg::SLNP_ASSIGN_CMD, {3'h0, own}});
			chk("own_addr", own, own_addr_out);
			chk("fwd_addr", 5'(own + 5'h01), up_tx_byte_out);
			LO.send(slnp_pkg::SLNP_K_STOP, 8'h00);
		end
		chk("fwd_stop", slnp_pkg::SLNP_K_STOP, up_tx_kind_out);
		for (int k = 0; k < 5; k++)
		begin
			tgt = (k == 0) ? own - 5'h01 : (k == 3) ? own + 5'h01 : own;
			r = 8'($random(seed));
			l8 = 8'($random(seed));
			h8 = 8'($random(seed));
			ub = '{wb(tgt), r, l8, h8};
			ub.push_back(crcq(ub) ^ {7'h00, k == 2});
			n0 = n_up;
			s0 = n_stb;
			if (k == 4)
			begin
				frame(ub[0:1]);
				uclk_run = 0;
				repeat (400) @(negedge clk_sys_in);
				uclk_run = 1;
				foreach (ub[i]) if (i > 1) LO.send(slnp_pkg::SLNP_K_BYTE, ub[i]);
			end
			else
				frame(ub);
			chk("write_fwd", (k == 3) ? 6 : 0, n_up - n0);
			chk("write_stb", k == 1, n_stb - s0);
			if (k == 1) chk("write_val", {r, h8, l8}, stb_v);
			if (k == 2) chk("write_alert", 1, crc_alert_status_out);
			if (k == 3) chk("write_fwd_byte", ub[4], up_tx_byte_out);
			LO.send(slnp_pkg::SLNP_K_STOP, 8'h00);
		end
		@(negedge clk_sys_in);
		crc_alarm_enable_in = 1;
		repeat (3) @(negedge clk_sys_in);
		chk("alarm", 1, alarm_out);
		crc_alert_clear_in = 1;
		@(negedge clk_sys_in);
		crc_alert_clear_in = 0;
		repeat (3) @(negedge clk_sys_in);
		chk("alarm_clr", 0, alarm_out);
		for (int m = 0; m < 3; m++)
		begin
			@(negedge clk_sys_in);
			last_addr_in = own + 5'(m > 0);
			// Keep the command byte off the assign code so the read frame stays a read
			r = 8'($random(seed)) & 8'h7F;
			reg_rd_data_in = 16'($random(seed));
			lower_alarm_line_in = 1'($random(seed));
			q.delete();
			frame('{slnp_pkg::SLNP_BCAST_WR, r});
			frame('{slnp_pkg::SLNP_BCAST_RD});
			ex = '{slnp_pkg::SLNP_BCAST_WR, r, slnp_pkg::SLNP_BCAST_RD, reg_rd_data_in[7:0], reg_rd_data_in[15:8]};
			h8 = {lower_alarm_line_in, 7'h00};
			if (m > 0)
			begin
				ub = '{ex[0], ex[1], ex[2], 8'($random(seed)), 8'($random(seed)), {1'($random(seed)), 7'h00}};
				ub.push_back(crcq(ub) ^ {7'h00, m == 2});
				foreach (ub[i]) if (i > 2) UP.send(slnp_pkg::SLNP_K_BYTE, ub[i]);
				ex.push_back(ub[3]);
				ex.push_back(ub[4]);
				h8 = h8 | ub[5] | {7'h00, m == 2};
			end
			ex.push_back(h8);
			ex.push_back(crcq(ex));
			repeat (ex.size() - 4) LO.send(slnp_pkg::SLNP_K_ACK, 8'h00);
			wq(ex.size() - 3);
			foreach (q[i])
				chk("read_byte", ex[i + 3], q[i]);
			chk("read_count", ex.size() - 3, q.size());
			chk("read_alert", m == 2, crc_alert_status_out);
			LO.send(slnp_pkg::SLNP_K_STOP, 8'h00);
		end
		give_verdict();
	end
endmodule
`default_nettype wire
